//--- common/scvd_consts.vh
// register offsets, field positions and reset values for the dma registers
// assumes byte addressing on a 32-bit apb bus
`ifndef SCVD_CONSTS_VH
`define SCVD_CONSTS_VH
`define SCVD_ADDR_W          12
`define SCVD_OFS_SND_CTRL    12'h190
`define SCVD_OFS_SND_STATE   12'h194
`define SCVD_OFS_CUR_FETCH   12'h1c0
`define SCVD_OFS_CUR_START   12'h1c4
`define SCVD_OFS_VLO_FETCH   12'h1c8
`define SCVD_OFS_VUP_FETCH   12'h1d0
`define SCVD_OFS_VBUF_LAST   12'h1d4
`define SCVD_OFS_VBUF_FIRST  12'h1d8
`define SCVD_OFS_VUP_ORIGIN  12'h1dc
`define SCVD_OFS_VLO_ORIGIN  12'h1e8
`define SCVD_CTRL_CLEAR      7
`define SCVD_CTRL_ENABLE     5
`define SCVD_CTRL_FIXED      5'h10
`define SCVD_FIXED_HI        4
`define SCVD_STATE_HI        2
`define SCVD_STATE_RESET     3'h6
`define SCVD_STATE_OVR_IRQ   3'h6
`define SCVD_PTR_HI          28
`define SCVD_PTR_LO          4
`define SCVD_END_HI          23
`define SCVD_LAST_BIT        30
`define SCVD_EQUAL_BIT       29
`define SCVD_PTR_W           25
`define SCVD_END_W           20
`endif

//--- hw/scvd_ptr.v
// one quadword fetch pointer: load from origin, step, software write
// the module itself gives load priority over step and write over both
`default_nettype none
module scvd_ptr (
   input  wire        clk,
   input  wire        resetn,
   input  wire        wr,
   input  wire [24:0] wr_val,
   input  wire        load,
   input  wire [24:0] load_val,
   input  wire        step,
   input  wire        wrap,
   input  wire [24:0] wrap_val,
   output reg  [24:0] ptr
);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ptr <= 25'h0;
      end else if (wr) begin
         ptr <= wr_val;
      end else if (load) begin
         ptr <= load_val;
      end else if (step) begin
         // stepping past the buffer end restarts at buffer start
         if (wrap) begin
            ptr <= wrap_val;
         end else begin
            ptr <= ptr + 25'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- hw/scvd_dma_regs.v
// sound, cursor and video dma register block with apb slave
// assumes the fetch engine pulses retrace and fetch strobes on clk
`default_nettype none
`include "scvd_consts.vh"
module scvd_dma_regs (
   input  wire        clk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        vertical_retrace_period,
   input  wire        cursor_fetch_done,
   input  wire        video_upper_fetch_done,
   input  wire        video_lower_fetch_done,
   input  wire [2:0]  sound_next_state,
   input  wire        sound_state_update,
   output reg         sound_enable,
   output reg  [24:0] cursor_fetch_addr,
   output reg  [24:0] video_upper_fetch_addr,
   output reg  [24:0] video_lower_fetch_addr,
   output reg         video_equal
);
   reg         ctrl_enable;
   reg  [2:0]  sound_dma_state;
   reg  [24:0] cursor_start_pointer;
   reg  [19:0] video_buffer_last;
   reg  [24:0] video_buffer_first;
   reg  [24:0] video_upper_frame_origin;
   reg         origin_last;
   reg  [24:0] video_lower_frame_origin;
   reg         retrace_q;
   wire [24:0] cursor_fetch_pointer;
   wire [24:0] video_upper_fetch_pointer;
   wire [24:0] video_lower_fetch_pointer;
   wire        wr_en;
   wire        rd_en;
   wire [24:0] wr_ptr;
   wire        retrace_start;
   wire        equal_up;
   wire        equal_lo;
   reg  [31:0] next_prdata;
   reg         next_pslverr;

   // write lands at the edge ending the access cycle, while pready is high
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & ~penable & ~pwrite;
   // low four address bits and bits above the field are dropped
   assign wr_ptr = pwdata[`SCVD_PTR_HI:`SCVD_PTR_LO];
   // one load per retrace period, on its leading edge
   assign retrace_start = vertical_retrace_period & ~retrace_q;

   // comparator on the end field only; upper pointer bits ignored
   assign equal_up = (video_upper_fetch_pointer[`SCVD_END_W-1:0] ==
                      video_buffer_last);
   assign equal_lo = (video_lower_fetch_pointer[`SCVD_END_W-1:0] ==
                      video_buffer_last);

   scvd_ptr u_cursor (
      .clk      (clk),
      .resetn   (resetn),
      .wr       (wr_en && paddr == `SCVD_OFS_CUR_FETCH),
      .wr_val   (wr_ptr),
      .load     (retrace_start),
      .load_val (cursor_start_pointer),
      .step     (cursor_fetch_done),
      .wrap     (1'b0),
      .wrap_val (25'h0),
      .ptr      (cursor_fetch_pointer)
   );

   scvd_ptr u_video_upper (
      .clk      (clk),
      .resetn   (resetn),
      .wr       (wr_en && paddr == `SCVD_OFS_VUP_FETCH),
      .wr_val   (wr_ptr),
      .load     (retrace_start),
      .load_val (video_upper_frame_origin),
      .step     (video_upper_fetch_done),
      .wrap     (equal_up),
      .wrap_val (video_buffer_first),
      .ptr      (video_upper_fetch_pointer)
   );

   scvd_ptr u_video_lower (
      .clk      (clk),
      .resetn   (resetn),
      .wr       (wr_en && paddr == `SCVD_OFS_VLO_FETCH),
      .wr_val   (wr_ptr),
      .load     (retrace_start),
      .load_val (video_lower_frame_origin),
      .step     (video_lower_fetch_done),
      .wrap     (equal_lo),
      .wrap_val (video_buffer_first),
      .ptr      (video_lower_fetch_pointer)
   );

   // per-register write strobes, taken at the edge ending the access
   wire        wr_ctrl;
   wire        wr_cur_start;
   wire        wr_last;
   wire        wr_first;
   wire        wr_up_origin;
   wire        wr_lo_origin;
   wire        clear_req;

   assign wr_ctrl      = wr_en & (paddr == `SCVD_OFS_SND_CTRL);
   assign wr_cur_start = wr_en & (paddr == `SCVD_OFS_CUR_START);
   assign wr_last      = wr_en & (paddr == `SCVD_OFS_VBUF_LAST);
   assign wr_first     = wr_en & (paddr == `SCVD_OFS_VBUF_FIRST);
   assign wr_up_origin = wr_en & (paddr == `SCVD_OFS_VUP_ORIGIN);
   assign wr_lo_origin = wr_en & (paddr == `SCVD_OFS_VLO_ORIGIN);
   // clear is a pulse: no storage, so it self-clears
   assign clear_req    = wr_ctrl & pwdata[`SCVD_CTRL_CLEAR];

   // retrace edge detector idles low like its pin: no edge after reset
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         retrace_q <= 1'b0;
      end else begin
         retrace_q <= vertical_retrace_period;
      end
   end

   // sound channel enable
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_enable <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_enable <= pwdata[`SCVD_CTRL_ENABLE];
      end
   end

   // cursor start pointer
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cursor_start_pointer <= 25'h0;
      end else if (wr_cur_start) begin
         cursor_start_pointer <= wr_ptr;
      end
   end

   // buffer last keeps only the end field
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_buffer_last <= 20'h0;
      end else if (wr_last) begin
         video_buffer_last <= pwdata[`SCVD_END_HI:`SCVD_PTR_LO];
      end
   end

   // buffer first, the wrap target
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_buffer_first <= 25'h0;
      end else if (wr_first) begin
         video_buffer_first <= wr_ptr;
      end
   end

   // upper origin; last flag is stored as written, never checked
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_upper_frame_origin <= 25'h0;
         origin_last              <= 1'b0;
      end else if (wr_up_origin) begin
         video_upper_frame_origin <= wr_ptr;
         origin_last              <= pwdata[`SCVD_LAST_BIT];
      end
   end

   // lower origin; its last bit is not stored
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_lower_frame_origin <= 25'h0;
      end else if (wr_lo_origin) begin
         video_lower_frame_origin <= wr_ptr;
      end
   end

   // sound state machine state; the clear write wins over the engine
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sound_dma_state <= `SCVD_STATE_RESET;
      end else if (clear_req) begin
         sound_dma_state <= `SCVD_STATE_OVR_IRQ;
      end else if (sound_state_update) begin
         sound_dma_state <= sound_next_state;
      end
   end

   // read mux
   always @* begin
      next_prdata  = 32'h0;
      next_pslverr = 1'b0;
      case (paddr)
         `SCVD_OFS_SND_CTRL: begin
            next_prdata[`SCVD_CTRL_ENABLE] = ctrl_enable;
            next_prdata[`SCVD_FIXED_HI:0] = `SCVD_CTRL_FIXED;
         end
         `SCVD_OFS_SND_STATE: begin
            next_prdata[`SCVD_STATE_HI:0] = sound_dma_state;
         end
         `SCVD_OFS_CUR_FETCH: begin
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] = cursor_fetch_pointer;
         end
         `SCVD_OFS_CUR_START: begin
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] = cursor_start_pointer;
         end
         `SCVD_OFS_VLO_FETCH: begin
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] =
               video_lower_fetch_pointer;
         end
         `SCVD_OFS_VUP_FETCH: begin
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] =
               video_upper_fetch_pointer;
         end
         `SCVD_OFS_VBUF_LAST: begin
            next_prdata[`SCVD_END_HI:`SCVD_PTR_LO] = video_buffer_last;
         end
         `SCVD_OFS_VBUF_FIRST: begin
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] = video_buffer_first;
         end
         `SCVD_OFS_VUP_ORIGIN: begin
            next_prdata[`SCVD_LAST_BIT] = origin_last;
            next_prdata[`SCVD_EQUAL_BIT] = equal_up;
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] =
               video_upper_frame_origin;
         end
         `SCVD_OFS_VLO_ORIGIN: begin
            next_prdata[`SCVD_EQUAL_BIT] = equal_lo;
            next_prdata[`SCVD_PTR_HI:`SCVD_PTR_LO] =
               video_lower_frame_origin;
         end
         default: begin
            next_pslverr = 1'b1;
         end
      endcase
   end

   // apb answer: always zero wait states
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_pslverr;
         if (rd_en) begin
            prdata <= next_prdata;
         end
      end
   end

   // enable to the engine, one cycle behind the register
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sound_enable <= 1'b0;
      end else begin
         sound_enable <= ctrl_enable;
      end
   end

   // fetch addresses lag the pointers by one cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cursor_fetch_addr <= 25'h0;
      end else begin
         cursor_fetch_addr <= cursor_fetch_pointer;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_upper_fetch_addr <= 25'h0;
      end else begin
         video_upper_fetch_addr <= video_upper_fetch_pointer;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_lower_fetch_addr <= 25'h0;
      end else begin
         video_lower_fetch_addr <= video_lower_fetch_pointer;
      end
   end

   // only the upper comparator leaves the block
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         video_equal <= 1'b0;
      end else begin
         video_equal <= equal_up;
      end
   end
endmodule
`default_nettype wire

//--- test/scvd_dma_regs_assertions.sv
// checker for the dma register block, bound to its ports
// assumes zero wait state apb and a single clock domain
`default_nettype none
module scvd_dma_regs_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        vertical_retrace_period,
   input wire logic        cursor_fetch_done,
   input wire logic        sound_enable,
   input wire logic [24:0] cursor_fetch_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   wire logic acc = psel & penable & pready;
   wire logic rd = acc & ~pwrite;
   AST_READY:
   assert property (psel && !penable |=> pready) else $error("late ready");
   AST_ERR_READY:
   assert property (pslverr |-> pready) else $error("stray error");
   AST_RESET_OFF:
   assert property ($rose(resetn) |-> !sound_enable) else $error("enable");
   AST_ENABLE:
   assert property (acc && pwrite && paddr == 12'h190
      |-> ##2 sound_enable == $past(pwdata[5], 2)) else $error("enable");
   AST_CTRL_READ:
   assert property (rd && paddr == 12'h190
      |-> prdata[7:6] == 2'b00 && prdata[4:0] == 5'h10) else $error("ctrl");
   AST_STATE_READ:
   assert property (rd && paddr == 12'h194 |-> prdata[31:3] == 29'h0)
      else $error("state upper bits");
   AST_PTR_NIBBLE:
   assert property (rd && paddr[11:4] == 8'h1c |-> prdata[3:0] == 4'h0)
      else $error("pointer low bits");
   AST_END_READ:
   assert property (rd && paddr == 12'h1d4 |-> prdata[31:24] == 8'h0)
      else $error("end upper bits");
   AST_ORIGIN_TOP:
   assert property (rd && paddr == 12'h1dc |-> !prdata[31]) else $error("b31");
   AST_CUR_STEP:
   assert property (cursor_fetch_done && !vertical_retrace_period && !psel
      |-> ##2 cursor_fetch_addr == $past(cursor_fetch_addr) + 25'd1)
      else $error("cursor step");
endmodule
`default_nettype wire

//--- test/scvd_mem_model.sv
// memory side model: fetch completions, retrace and sound engine state
// assumes the bench calls its tasks between register transfers
`default_nettype none
module scvd_mem_model (
   input  wire logic  clk,
   output logic       retrace,
   output logic       done,
   output logic [2:0] state,
   output logic       upd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      retrace = 1'b0;
      done = 1'b0;
      state = 3'h0;
      upd = 1'b0;
   end
   // one quadword returned on every channel at once
   task fetch();
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task frame();
      @(posedge clk);
      retrace <= 1'b1;
      @(posedge clk);
      retrace <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task snd(input logic [2:0] s);
      @(posedge clk);
      state <= s;
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- test/scvd_dma_regs_tb.sv
// self-checking bench for the dma register block
// assumes the memory model drives the fetch and sound engine side
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module scvd_dma_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, resetn = 1'b0, e, se, veq, rt, dn, su;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0]  ss;
   logic [24:0] ca, ua, la;
   int          num_errors = 0, checked = 0;
   always #20 clk = ~clk;
   scvd_dma_regs scvd_dma_regs_i (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr,
      .vertical_retrace_period(rt), .cursor_fetch_done(dn),
      .video_upper_fetch_done(dn), .video_lower_fetch_done(dn),
      .sound_next_state(ss), .sound_state_update(su), .sound_enable(se),
      .cursor_fetch_addr(ca), .video_upper_fetch_addr(ua),
      .video_lower_fetch_addr(la), .video_equal(veq));
   scvd_mem_model scvd_mem_model_i (.clk, .retrace(rt), .done(dn),
      .state(ss), .upd(su));
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task t_ctrl();
      apb(0, 12'h190, 0);
      `CHK("ctrl", 32'h10, r)
      apb(1, 12'h190, 32'hffffffff);
      apb(0, 12'h190, 0);
      `CHK("ctrl", 32'h30, r)
      `CHK("enable", 1'b1, se)
      apb(1, 12'h190, 32'h5f);
      apb(0, 12'h190, 0);
      `CHK("ctrl", 32'h10, r)
   endtask
   task t_state();
      apb(0, 12'h194, 0);
      `CHK("state", 32'h6, r)
      scvd_mem_model_i.snd(3'h1);
      apb(1, 12'h194, 32'hff);
      `CHK("err", 1'b0, e)
      apb(0, 12'h194, 0);
      `CHK("state", 32'h1, r)
      apb(1, 12'h190, 32'h80);
      apb(0, 12'h194, 0);
      `CHK("state", 32'h6, r)
      // clear must not keep forcing the engine afterwards
      scvd_mem_model_i.snd(3'h2);
      apb(0, 12'h194, 0);
      `CHK("state", 32'h2, r)
   endtask
   task automatic t_ptr();
      logic [11:0] a[5] = '{12'h1c0, 12'h1c8, 12'h1d0, 12'h1d4, 12'h1d8};
      logic [31:0] x[5] = '{32'h1ffffff0, 32'h1ffffff0, 32'h1ffffff0,
                            32'h00fffff0, 32'h1ffffff0};
      for (int i = 0; i < 5; i++) begin
         apb(1, a[i], 32'hffffffff);
         apb(0, a[i], 0);
         `CHK("ptr", x[i], r)
      end
      apb(1, 12'h1dc, 32'hbfffffff);
      apb(0, 12'h1dc, 0);
      `CHK("origin", 32'h1ffffff0, r & 32'hdfffffff)
      apb(1, 12'h1dc, 32'h40fffff0);
      apb(0, 12'h1dc, 0);
      `CHK("last", 2'b01, r[31:30])
      apb(0, 12'h1e4, 0);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, r)
   endtask
   task t_frame();
      apb(1, 12'h1c4, 32'h100);
      apb(1, 12'h1dc, 32'h200);
      apb(1, 12'h1e8, 32'h300);
      scvd_mem_model_i.frame();
      `CHK("cursor", 25'h10, ca)
      `CHK("upper", 25'h20, ua)
      `CHK("lower", 25'h30, la)
      scvd_mem_model_i.fetch();
      scvd_mem_model_i.fetch();
      `CHK("cursor", 25'h12, ca)
      `CHK("upper", 25'h22, ua)
      apb(0, 12'h1c0, 0);
      `CHK("cursor reg", 32'h120, r)
   endtask
   task t_wrap();
      apb(1, 12'h1d4, 32'h40);
      apb(1, 12'h1d8, 32'h10);
      apb(1, 12'h1dc, 32'h30);
      scvd_mem_model_i.frame();
      scvd_mem_model_i.fetch();
      `CHK("equal", 1'b1, veq)
      apb(0, 12'h1dc, 0);
      `CHK("equal bit", 1'b1, r[29])
      scvd_mem_model_i.fetch();
      `CHK("wrap", 25'h1, ua)
   endtask
   task tally_and_finish();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_ctrl();
      t_state();
      t_ptr();
      t_frame();
      t_wrap();
      tally_and_finish();
   end
   // whole run is about 140 cycles
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
endmodule
bind scvd_dma_regs scvd_dma_regs_chk scvd_dma_regs_chk_i (.clk, .resetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .vertical_retrace_period, .cursor_fetch_done, .sound_enable,
   .cursor_fetch_addr);
`default_nettype wire
